// ===== hw/qhd_port.sv
/*
 * Queue host data port: packet size, transmit setup, transmit data into the
 * queue, receive data out of it, block pointers and receive done status.
 * Assumes one host request per cycle on a synchronous pseudo-SRAM style bus.
 */
// Behaviour
// - Holds 16-bit packet byte size, read/write.
// - Byte-order bit picks MSB-first or LSB-first.
// - Start offset drops first-word bytes while counting.
// - End offset drops last-word bytes at zero.
// - End offset stays until host clears it.
// - Remaining size under four overrides end offset.
// - Countdown decrements per write, then holds zero.
// - Transmit data writes append words to queue.
// - Receive data reads shift queue; check status.
// - First and last block pointers, reset zero.
// - Done bit shows packet finished entering.
`timescale 1ns/1ps
module qhd_port
	import qhd_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	input  wire qhd_pkg::qhd_host_req_t host_req_in,
	output logic      [31:0]           host_rdata_out,
	output logic                       host_rvalid_out,
	output qhd_pkg::qhd_qwr_t          qwr_out,
	input  wire logic                  rx_wr_in,
	input  wire logic [31:0]           rx_data_in,
	input  wire logic                  rx_done_in,
	output logic                       rx_full_out
);
	import qhd_pkg::*;

	logic [SIZE_W-1:0]  size_reg, size_next;
	logic               endian_reg, endian_next;
	logic [1:0]         start_reg, start_next;
	logic [1:0]         end_reg, end_next;
	logic [COUNT_W-1:0] count_reg, count_next;
	logic [15:0]        remain_reg, remain_next;
	logic [PTR_W-1:0]   first_reg, first_next;
	logic [PTR_W-1:0]   last_reg, last_next;
	logic               done_reg, done_next;
	logic [31:0]        rdata_next;
	logic               rvalid_next;
	qhd_qwr_t           qwr_next;

	logic               wr_acc, rd_acc;
	logic               wr_size, wr_setup, wr_data, wr_ptrs, rd_rx;
	logic               counting;
	logic [3:0]         byte_en;
	logic [2:0]         kept;
	logic [31:0]        rx_word;
	logic               rx_empty;

	assign wr_acc   = host_req_in.cs && host_req_in.wr;
	assign rd_acc   = host_req_in.cs && host_req_in.rd;
	assign wr_size  = wr_acc && (host_req_in.addr == OFF_PKT_SIZE);
	assign wr_setup = wr_acc && (host_req_in.addr == OFF_TX_SETUP);
	assign wr_data  = wr_acc && (host_req_in.addr == OFF_TX_DATA);
	assign wr_ptrs  = wr_acc && (host_req_in.addr == OFF_BLK_PTRS);
	assign rd_rx    = rd_acc && (host_req_in.addr == OFF_RX_DATA);
	assign counting = (count_reg != '0);

	// Offsets are gated here so the mask module stays a pure lane mapper.
	qhd_byte_mask u_mask (
		.start_off_in  (counting ? start_reg : 2'b00),
		.end_off_in    (counting ? 2'b00 : end_reg),
		.remain_in     (remain_reg),
		.big_endian_in (endian_reg),
		.byte_en_out   (byte_en),
		.kept_out      (kept)
	);

	qhd_rx_mem u_rx (
		.clk_in      (clk_in),
		.srst_in     (srst_in),
		.wr_en_in    (rx_wr_in),
		.wr_data_in  (rx_data_in),
		.rd_en_in    (rd_rx),
		.rd_data_out (rx_word),
		.empty_out   (rx_empty),
		.full_out    (rx_full_out)
	);

	always_comb begin
		size_next   = size_reg;
		endian_next = endian_reg;
		start_next  = start_reg;
		end_next    = end_reg;
		count_next  = count_reg;
		remain_next = remain_reg;
		first_next  = first_reg;
		last_next   = last_reg;
		qwr_next    = '0;
		if (wr_size) begin
			size_next = host_req_in.wdata[SIZE_LSB +: SIZE_W];
		end
		if (wr_setup) begin
			endian_next = host_req_in.wdata[ENDIAN_BIT];
			start_next  = host_req_in.wdata[START_LSB +: 2];
			end_next    = host_req_in.wdata[END_LSB +: 2];
			count_next  = host_req_in.wdata[COUNT_LSB +: COUNT_W];
			// The remainder restarts from the size, which must already be set.
			remain_next = size_reg;
		end
		if (wr_data) begin
			qwr_next.valid      = 1'b1;
			qwr_next.data       = host_req_in.wdata;
			qwr_next.byte_en    = byte_en;
			qwr_next.last       = !counting;
			qwr_next.big_endian = endian_reg;
			remain_next = 16'(remain_reg - {13'h0000, kept});
			if (counting) begin
				count_next = COUNT_W'(count_reg - 1'b1);
				start_next = 2'b00;
			end
			// At zero the countdown and end offset are simply kept.
		end
		if (wr_ptrs) begin
			last_next  = host_req_in.wdata[LAST_LSB +: PTR_W];
			first_next = host_req_in.wdata[FIRST_LSB +: PTR_W];
		end
		// A new done event wins over the clear caused by draining.
		if (rx_done_in) begin
			done_next = 1'b1;
		end else if (rx_empty) begin
			done_next = 1'b0;
		end else begin
			done_next = done_reg;
		end
	end

	always_comb begin
		rvalid_next = rd_acc;
		rdata_next  = REG_RESET;
		if (rd_acc) begin
			unique case (host_req_in.addr)
				OFF_PKT_SIZE: rdata_next = {16'h0000, size_reg};
				OFF_TX_SETUP: rdata_next = {7'h00, endian_reg, 4'h0, start_reg, end_reg,
					2'b00, count_reg};
				OFF_RX_DATA:  rdata_next = rx_word;
				OFF_BLK_PTRS: rdata_next = {9'h000, last_reg, 9'h000, first_reg};
				OFF_RX_STATUS: rdata_next = {done_reg, 31'h0000_0000};
				default:      rdata_next = REG_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			size_reg        <= '0;
			endian_reg      <= 1'b0;
			start_reg       <= 2'b00;
			end_reg         <= 2'b00;
			count_reg       <= '0;
			remain_reg      <= '0;
			first_reg       <= PTR_RESET;
			last_reg        <= PTR_RESET;
			done_reg        <= 1'b0;
			host_rdata_out  <= REG_RESET;
			host_rvalid_out <= 1'b0;
			qwr_out         <= '0;
		end else begin
			size_reg        <= size_next;
			endian_reg      <= endian_next;
			start_reg       <= start_next;
			end_reg         <= end_next;
			count_reg       <= count_next;
			remain_reg      <= remain_next;
			first_reg       <= first_next;
			last_reg        <= last_next;
			done_reg        <= done_next;
			host_rdata_out  <= rdata_next;
			host_rvalid_out <= rvalid_next;
			qwr_out         <= qwr_next;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	a_size_store: assert property (
		wr_size |=> size_reg == $past(host_req_in.wdata[15:0]))
		else $error("packet size not stored");

	a_start_lane: assert property (
		wr_data && counting && start_reg == 2'b01 && remain_reg >= 16'h0004
		|=> qwr_out.byte_en == (qwr_out.big_endian ? 4'b0111 : 4'b1110))
		else $error("start offset dropped wrong lane");

	a_start_clears: assert property (
		wr_data && counting |=> start_reg == 2'b00)
		else $error("start offset did not clear");

	a_end_sticky: assert property (
		wr_data && !counting |=> end_reg == $past(end_reg) && count_reg == '0)
		else $error("end offset or zero countdown changed");

	a_short_tail: assert property (
		wr_data && !counting && remain_reg == 16'h0001
		|=> $countones(qwr_out.byte_en) == 1 && remain_reg == 16'h0000)
		else $error("short remainder not honoured");

	a_count_step: assert property (
		wr_data && counting |=> count_reg == $past(count_reg) - 14'h0001)
		else $error("countdown did not decrement");

	a_data_append: assert property (
		wr_data |=> qwr_out.valid && qwr_out.data == $past(host_req_in.wdata))
		else $error("transmit word not appended");

	a_ptr_store: assert property (
		wr_ptrs |=> first_reg == $past(host_req_in.wdata[6:0])
			&& last_reg == $past(host_req_in.wdata[22:16]))
		else $error("block pointers not stored");

	a_done_set: assert property (
		rx_done_in |=> done_reg)
		else $error("done bit not set");

	a_setup_load: assert property (
		wr_setup |=> count_reg == $past(host_req_in.wdata[13:0])
			&& remain_reg == $past(size_reg))
		else $error("setup did not reload");

	// Holding checks catch a stray update that the scenario checks would miss.
	a_end_lane: assert property (
		wr_data && !counting && end_reg == 2'b01 && remain_reg >= 16'h0004
		|=> qwr_out.byte_en == (qwr_out.big_endian ? 4'b1110 : 4'b0111))
		else $error("end offset dropped wrong lane");

	a_end_hold: assert property (
		!wr_setup |=> end_reg == $past(end_reg))
		else $error("end offset changed without setup");

	a_zero_keep: assert property (
		wr_data && remain_reg == 16'h0000 |=> qwr_out.byte_en == 4'b0000)
		else $error("empty remainder kept bytes");

	a_remain_step: assert property (
		wr_data |=> remain_reg == 16'($past(remain_reg) - 16'($countones(qwr_out.byte_en))))
		else $error("remaining size not reduced by kept bytes");

	a_count_hold: assert property (
		!wr_data && !wr_setup |=> count_reg == $past(count_reg))
		else $error("countdown moved without a write");

	a_last_flag: assert property (
		wr_data |=> qwr_out.last == ($past(count_reg) == 14'h0000))
		else $error("last flag does not match countdown");

	a_start_hold: assert property (
		!wr_setup && !wr_data |=> start_reg == $past(start_reg))
		else $error("start offset changed without a write");

	a_order_tag: assert property (
		wr_data |=> qwr_out.big_endian == $past(endian_reg))
		else $error("byte order not carried with word");

	a_qwr_idle: assert property (
		!wr_data |=> qwr_out == '0)
		else $error("queue write without host write");

	a_read_pulse: assert property (
		rd_acc |=> host_rvalid_out)
		else $error("read not answered");

	a_read_idle: assert property (
		!rd_acc |=> !host_rvalid_out && host_rdata_out == 32'h0000_0000)
		else $error("read answer without read");

	a_rx_word: assert property (
		rd_rx |=> host_rdata_out == $past(rx_word))
		else $error("receive word not returned");

	a_status_read: assert property (
		rd_acc && host_req_in.addr == OFF_RX_STATUS
		|=> host_rdata_out == {$past(done_reg), 31'h0000_0000})
		else $error("status read wrong");

	a_done_clear: assert property (
		!rx_done_in && rx_empty |=> !done_reg)
		else $error("done bit not cleared on empty store");

	a_size_hold: assert property (
		!wr_size |=> size_reg == $past(size_reg))
		else $error("packet size changed without write");

	a_ptr_hold: assert property (
		!wr_ptrs |=> first_reg == $past(first_reg) && last_reg == $past(last_reg))
		else $error("block pointers changed without write");

	a_ptr_read: assert property (
		rd_acc && host_req_in.addr == OFF_BLK_PTRS
		|=> host_rdata_out == {9'h000, $past(last_reg), 9'h000, $past(first_reg)})
		else $error("block pointer read wrong");

	c_full_buffer: cover property (wr_setup ##[1:4] wr_data ##[1:4] wr_data ##1 qwr_out.last);
	c_rx_pop: cover property (rd_rx && !rx_empty ##1 host_rvalid_out);
	c_short_tail: cover property (wr_data && remain_reg < 16'h0004 && remain_reg != 16'h0000);
	c_big_tail: cover property (wr_data && endian_reg && !counting && end_reg != 2'b00);
	c_done_read: cover property (rd_acc && host_req_in.addr == OFF_RX_STATUS && done_reg);
endmodule // qhd_port

// ===== pkg/qhd_pkg.sv
/*
 * Shared constants and carrier types for the queue host data port.
 * Assumes a single 50 MHz host bus clock and a synchronous active-high reset.
 */
package qhd_pkg;

	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 32;

	localparam logic [ADDR_W-1:0] OFF_PKT_SIZE  = 10'h004;
	localparam logic [ADDR_W-1:0] OFF_TX_SETUP  = 10'h008;
	localparam logic [ADDR_W-1:0] OFF_TX_DATA   = 10'h00c;
	localparam logic [ADDR_W-1:0] OFF_RX_DATA   = 10'h010;
	localparam logic [ADDR_W-1:0] OFF_BLK_PTRS  = 10'h018;
	localparam logic [ADDR_W-1:0] OFF_RX_STATUS = 10'h104;

	localparam int unsigned SIZE_LSB    = 0;
	localparam int unsigned SIZE_W      = 16;
	localparam int unsigned ENDIAN_BIT  = 24;
	localparam int unsigned START_LSB   = 18;
	localparam int unsigned END_LSB     = 16;
	localparam int unsigned COUNT_LSB   = 0;
	localparam int unsigned COUNT_W     = 14;
	localparam int unsigned LAST_LSB    = 16;
	localparam int unsigned FIRST_LSB   = 0;
	localparam int unsigned PTR_W       = 7;
	localparam int unsigned DONE_BIT    = 31;

	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
	localparam logic [PTR_W-1:0]  PTR_RESET = 7'h00;

	localparam int unsigned RX_DEPTH = 16;
	localparam int unsigned RX_AW    = 4;

	typedef struct packed {
		logic              cs;
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} qhd_host_req_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
		logic [3:0]        byte_en;
		logic              last;
		logic              big_endian;
	} qhd_qwr_t;

endpackage

// ===== hw/qhd_byte_mask.sv
/*
 * Byte keep mask for one word written to the queue.
 * Assumes offsets are already gated by the caller with the countdown state.
 */
`timescale 1ns/1ps
module qhd_byte_mask (
	input  wire logic [1:0]  start_off_in,
	input  wire logic [1:0]  end_off_in,
	input  wire logic [15:0] remain_in,
	input  wire logic        big_endian_in,
	output logic      [3:0]  byte_en_out,
	output logic      [2:0]  kept_out
);
	logic [2:0] end_n;
	logic [3:0] keep_ord;

	always_comb begin
		// A short remainder decides the tail in place of the end offset.
		if (remain_in < 16'h0004) begin
			end_n = 3'(3'd4 - remain_in[2:0]);
		end else begin
			end_n = {1'b0, end_off_in};
		end
		kept_out = 3'd0;
		for (int i = 0; i < 4; i++) begin
			keep_ord[i] = (i >= int'(start_off_in)) && (i < 4 - int'(end_n));
			kept_out = 3'(kept_out + {2'b00, keep_ord[i]});
		end
		for (int i = 0; i < 4; i++) begin
			byte_en_out[i] = big_endian_in ? keep_ord[3-i] : keep_ord[i];
		end
	end
endmodule // qhd_byte_mask

// ===== hw/qhd_rx_mem.sv
/*
 * Small receive word store, shifted out one word per pop.
 * Assumes the writer stops on full; read data lags a new head by one cycle.
 */
`timescale 1ns/1ps
module qhd_rx_mem
	import qhd_pkg::*;
(
	input  wire logic                       clk_in,
	input  wire logic                       srst_in,
	input  wire logic                       wr_en_in,
	input  wire logic [qhd_pkg::DATA_W-1:0] wr_data_in,
	input  wire logic                       rd_en_in,
	output logic      [qhd_pkg::DATA_W-1:0] rd_data_out,
	output logic                            empty_out,
	output logic                            full_out
);
	import qhd_pkg::*;

	logic [DATA_W-1:0] mem [RX_DEPTH];
	logic [RX_AW-1:0]  wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [RX_AW:0]    cnt_reg, cnt_next;
	logic              do_wr, do_rd;
	logic              empty_next, full_next;

	always_comb begin
		do_wr     = wr_en_in && !full_out;
		do_rd     = rd_en_in && !empty_out;
		wptr_next = do_wr ? RX_AW'(wptr_reg + 1'b1) : wptr_reg;
		rptr_next = do_rd ? RX_AW'(rptr_reg + 1'b1) : rptr_reg;
		cnt_next  = (RX_AW+1)'(cnt_reg + {{RX_AW{1'b0}}, do_wr} - {{RX_AW{1'b0}}, do_rd});
		empty_next = (cnt_next == '0);
		full_next  = (cnt_next == (RX_AW+1)'(RX_DEPTH));
	end

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem[wptr_reg] <= wr_data_in;
		end
		// Registered read keeps the read path off the host bus timing.
		rd_data_out <= mem[rptr_reg];
		if (srst_in) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			cnt_reg   <= '0;
			empty_out <= 1'b1;
			full_out  <= 1'b0;
		end else begin
			wptr_reg  <= wptr_next;
			rptr_reg  <= rptr_next;
			cnt_reg   <= cnt_next;
			empty_out <= empty_next;
			full_out  <= full_next;
		end
	end
endmodule // qhd_rx_mem

// ===== dv/qhd_host_model.sv
/*
 * Host processor model for the queue host data port bus.
 * Assumes the port takes a request at the first edge that sees cs high.
 */
`timescale 1ns/1ps
module qhd_host_model
	import qhd_pkg::*;
(
	input  wire logic               clk_in,
	output qhd_pkg::qhd_host_req_t  req_out
);
	import qhd_pkg::*;

	initial begin
		req_out = '0;
	end

	// The request is held across exactly one taking edge, then dropped.
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_in);
		req_out <= '{cs: 1'b1, wr: wr, rd: !wr, addr: a, wdata: d};
		@(posedge clk_in);
		req_out <= '0;
	endtask

	// Size goes in before setup, and the countdown is the word count less one.
	task automatic start_tx(input logic [15:0] size, input logic [31:0] flags, input int n);
		access(1'b1, OFF_PKT_SIZE, {16'h0000, size});
		access(1'b1, OFF_TX_SETUP, flags | 32'(n - 1));
	endtask
endmodule // qhd_host_model

// ===== dv/queue_host_data_port_tb.sv
/*
 * Self-checking bench for the queue host data port.
 * Assumes the host model drives the bus and results are checked in order.
 */
`timescale 1ns/1ps
module queue_host_data_port_tb;
	import qhd_pkg::*;

	logic          clk_in    = 1'b0;
	logic          srst_in   = 1'b1;
	qhd_host_req_t host_req;
	logic [31:0]   host_rdata;
	logic          host_rvalid;
	qhd_qwr_t      qwr;
	logic          rx_wr     = 1'b0;
	logic          rx_done   = 1'b0;
	logic [31:0]   rx_data   = 32'h0000_0000;
	logic          rx_full;
	int            bad_count = 0;
	int            checked   = 0;
	int            cycles    = 0;
	logic [31:0]   exp_rd[$];
	qhd_qwr_t      exp_q[$];
	logic [31:0]   d;
	logic [31:0]   w0;
	logic [31:0]   w1;

	initial forever #10 clk_in = ~clk_in;

	qhd_host_model u_host (.clk_in(clk_in), .req_out(host_req));

	qhd_port u_dut (
		.clk_in(clk_in), .srst_in(srst_in), .host_req_in(host_req),
		.host_rdata_out(host_rdata), .host_rvalid_out(host_rvalid), .qwr_out(qwr),
		.rx_wr_in(rx_wr), .rx_data_in(rx_data), .rx_done_in(rx_done), .rx_full_out(rx_full)
	);

	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] host_rdata_out expected %h seen %h", e, s);
		end
	endtask

	task automatic cmp_q(input qhd_qwr_t e, input qhd_qwr_t s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] qwr_out expected %h seen %h", e, s);
		end
	endtask

	task automatic cmp_full(input logic e, input logic s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] rx_full_out expected %b seen %b", e, s);
		end
	endtask

	task automatic wrap_up();
		if (exp_rd.size() != 0 || exp_q.size() != 0) begin
			bad_count++;
		end
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		u_host.access(1'b0, a, 32'h0000_0000);
	endtask

	task automatic qexp(input logic [31:0] v, input logic [3:0] be, input logic l, input logic b);
		exp_q.push_back('{valid: 1'b1, data: v, byte_en: be, last: l, big_endian: b});
		u_host.access(1'b1, OFF_TX_DATA, v);
	endtask

	// A result with no note behind it is itself a mismatch.
	always @(posedge clk_in) begin
		cycles++;
		if (host_rvalid === 1'b1) begin
			if (exp_rd.size() == 0) bad_count++;
			else cmp_rd(exp_rd.pop_front(), host_rdata);
		end
		if (qwr.valid === 1'b1) begin
			if (exp_q.size() == 0) bad_count++;
			else cmp_q(exp_q.pop_front(), qwr);
		end
		if (cycles >= 5000) begin
			bad_count++;
			wrap_up();
		end
	end

	initial begin
		void'($urandom(57831));
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		rd_exp(OFF_PKT_SIZE, 32'h0000_0000);
		rd_exp(OFF_TX_SETUP, 32'h0000_0000);
		rd_exp(OFF_BLK_PTRS, 32'h0000_0000);
		rd_exp(OFF_RX_STATUS, 32'h0000_0000);
		rd_exp(OFF_TX_DATA, 32'h0000_0000);
		rd_exp(10'h020, 32'h0000_0000);
		d = $urandom;
		u_host.access(1'b1, OFF_PKT_SIZE, d);
		rd_exp(OFF_PKT_SIZE, {16'h0000, d[15:0]});
		d = $urandom;
		u_host.access(1'b1, OFF_BLK_PTRS, d);
		rd_exp(OFF_BLK_PTRS, d & 32'h007f_007f);
		w0 = $urandom;
		w1 = $urandom;
		u_host.start_tx(16'h0006, 32'h0004_0000, 2);
		qexp(w0, 4'b1110, 1'b0, 1'b0);
		qexp(w1, 4'b0111, 1'b1, 1'b0);
		qexp(w0, 4'b0000, 1'b1, 1'b0);
		rd_exp(OFF_TX_SETUP, 32'h0000_0000);
		u_host.start_tx(16'h0010, 32'h0101_0000, 1);
		qexp(w0, 4'b1110, 1'b1, 1'b1);
		qexp(w1, 4'b1110, 1'b1, 1'b1);
		rd_exp(OFF_TX_SETUP, 32'h0101_0000);
		u_host.start_tx(16'h0005, 32'h0000_0000, 2);
		qexp(w1, 4'b1111, 1'b0, 1'b0);
		qexp(w0, 4'b0001, 1'b1, 1'b0);
		@(posedge clk_in);
		rx_wr <= 1'b1;
		rx_data <= w0;
		@(posedge clk_in);
		rx_data <= w1;
		@(posedge clk_in);
		rx_wr <= 1'b0;
		rx_done <= 1'b1;
		@(posedge clk_in);
		rx_done <= 1'b0;
		rd_exp(OFF_RX_STATUS, 32'h8000_0000);
		rd_exp(OFF_RX_DATA, w0);
		rd_exp(OFF_RX_DATA, w1);
		rd_exp(OFF_RX_STATUS, 32'h0000_0000);
		rx_wr <= 1'b1;
		repeat (RX_DEPTH) @(posedge clk_in);
		rx_wr <= 1'b0;
		repeat (2) @(posedge clk_in);
		cmp_full(1'b1, rx_full);
		repeat (5) @(posedge clk_in);
		wrap_up();
	end
endmodule // queue_host_data_port_tb
